// file: hw/sbt_consts.svh
// Overview of operation
// - Host bytes arrive over the register port and are held for sending.
// - Held byte moves into a parallel-load shifter and leaves bit-serially on serial_out.
// - Only the sequencer decides when the shifter loads and when it shifts.
// - The shift tick comes from base_clock through a programmable frequency scaler.
// - Host writes a division value; the scaler uses it as its ratio.
// - A capture command snapshots scaler count and shifter without disturbing transmission.
// - Host reads either snapshot back over the data port.
// - Holding, scaler, and both snapshot registers are eight bits wide.
// - Eight-bit down-counter; at zero it pulses shift_tick and reloads the value minus one.
// - Eight states S0..S7, one per tick; S0 loads, S1 raises reload request.
// - Reload request holds until a read at register_select high and low both set.
// - Reset clears shifter, scaler counter, reload request and returns sequencer to S0.
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH

// Register select values {register_select_high, register_select_low}
`define SBT_ADDR_SCALE    2'h0
`define SBT_ADDR_SERIAL_OUT   2'h1
`define SBT_ADDR_CAPTURE  2'h2
`define SBT_ADDR_STATUS   2'h3

// Status register fields
`define SBT_STAT_FLAG_BIT 0
`define SBT_STAT_FULL_BIT 1
`define SBT_STAT_SEQ_LSB  2

// Reset values
`define SBT_RST_BYTE      8'h00
`define SBT_RST_SCALE     8'h00
`define SBT_RST_PTR       1'h0
`define SBT_RST_COUNT     2'h0
`define SBT_FIFO_FULL     2'h2

`endif

// file: hw/sbt_pkg.sv
package sbt_pkg;

    // Sequencer states, Gray coded along S0..S7
    typedef enum logic [2:0] {
        SEQ_S0 = 3'h0,
        SEQ_S1 = 3'h1,
        SEQ_S2 = 3'h3,
        SEQ_S3 = 3'h2,
        SEQ_S4 = 3'h6,
        SEQ_S5 = 3'h7,
        SEQ_S6 = 3'h5,
        SEQ_S7 = 3'h4
    } sbt_seq_type;

    typedef struct packed {
        sbt_seq_type seq;
        logic [7:0]  shifter;
        logic [7:0]  last_byte;
        logic [7:0]  scale;
        logic        flag;
        logic [7:0]  snap_scaler;
        logic [7:0]  snap_shift;
        logic        serial;
        logic [7:0]  rd_data;
    } sbt_top_state_type;

    typedef struct packed {
        logic [7:0] count;
    } sbt_scaler_state_type;

    typedef struct packed {
        logic [1:0][7:0] mem;
        logic            wptr;
        logic            rptr;
        logic [1:0]      count;
    } sbt_fifo_state_type;

endpackage

// file: hw/sbt_scaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbt_consts.svh"

module sbt_scaler (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] scale,
    output logic            shift_tick,
    output logic [7:0]      count
);
    import sbt_pkg::*;

    sbt_scaler_state_type state_reg;
    sbt_scaler_state_type state_next;

    // Tick at zero; reload with value minus one so the period equals the value
    always_comb begin
        state_next = state_reg;
        if (state_reg.count == 8'h00) begin
            state_next.count = scale - 8'h01;  // Zero wraps to 255: divide by 256
        end else begin
            state_next.count = state_reg.count - 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // A new scale value only takes effect at the next reload
    assign shift_tick = (state_reg.count == 8'h00);
    assign count      = state_reg.count;

endmodule
`default_nettype wire

// file: hw/sbt_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbt_consts.svh"

module sbt_fifo2 (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       in_valid,
    output logic            in_ready,
    input  wire logic [7:0] in_data,
    output logic            out_valid,
    input  wire logic       out_ready,
    output logic [7:0]      out_data
);
    import sbt_pkg::*;

    sbt_fifo_state_type state_reg;
    sbt_fifo_state_type state_next;
    logic               push;
    logic               pop;

    assign in_ready  = (state_reg.count != `SBT_FIFO_FULL);
    assign out_valid = (state_reg.count != `SBT_RST_COUNT);
    assign out_data  = state_reg.mem[state_reg.rptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Two entries so a byte can wait while the shifter is still busy
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.mem[state_reg.wptr] = in_data;
            state_next.wptr                = ~state_reg.wptr;
        end
        if (pop) begin
            state_next.rptr = ~state_reg.rptr;
        end
        state_next.count = state_reg.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule
`default_nettype wire

// file: hw/sbt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbt_consts.svh"

module sbt_top (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    output logic            tx_ready,
    output logic            serial_out,
    output logic            reload_request_flag
);
    import sbt_pkg::*;

    sbt_top_state_type state_reg;
    sbt_top_state_type state_next;
    logic              shift_tick;
    logic [7:0]        scaler_count;
    logic              buf_valid;
    logic              buf_ready;
    logic [7:0]        buf_data;
    logic              wr_tx;
    logic              load_now;

    // Host byte writes go straight into the buffer; a full buffer refuses them
    assign wr_tx    = reg_wr && (reg_addr == `SBT_ADDR_SERIAL_OUT);
    // Buffer drains only when the sequencer loads the shifter
    assign load_now  = shift_tick && (state_reg.seq == SEQ_S0);
    assign buf_ready = load_now;

    sbt_scaler u_scaler (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .scale      (state_reg.scale),
        .shift_tick (shift_tick),
        .count      (scaler_count)
    );

    sbt_fifo2 u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_valid  (wr_tx),
        .in_ready  (tx_ready),
        .in_data   (reg_wdata),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_data)
    );

    // Sequencer, shifter, registers and read path
    always_comb begin
        state_next         = state_reg;
        state_next.rd_data = 8'h00;

        // Scale value write
        if (reg_wr && (reg_addr == `SBT_ADDR_SCALE)) begin
            state_next.scale = reg_wdata;
        end

        // One state per tick; S0 loads, the other seven shift
        if (shift_tick) begin
            unique case (state_reg.seq)
                SEQ_S0: begin
                    // Empty buffer: resend the previous byte rather than stall the line
                    state_next.shifter   = buf_valid ? buf_data : state_reg.last_byte;
                    state_next.last_byte = state_next.shifter;
                    state_next.seq       = SEQ_S1;
                end
                SEQ_S1: begin
                    state_next.shifter = {1'b0, state_reg.shifter[7:1]};  // LSB first
                    state_next.seq     = SEQ_S2;
                end
                SEQ_S2: begin
                    state_next.shifter = {1'b0, state_reg.shifter[7:1]};
                    state_next.seq     = SEQ_S3;
                end
                SEQ_S3: begin
                    state_next.shifter = {1'b0, state_reg.shifter[7:1]};
                    state_next.seq     = SEQ_S4;
                end
                SEQ_S4: begin
                    state_next.shifter = {1'b0, state_reg.shifter[7:1]};
                    state_next.seq     = SEQ_S5;
                end
                SEQ_S5: begin
                    state_next.shifter = {1'b0, state_reg.shifter[7:1]};
                    state_next.seq     = SEQ_S6;
                end
                SEQ_S6: begin
                    state_next.shifter = {1'b0, state_reg.shifter[7:1]};
                    state_next.seq     = SEQ_S7;
                end
                SEQ_S7: begin
                    state_next.shifter = {1'b0, state_reg.shifter[7:1]};
                    state_next.seq     = SEQ_S0;
                end
            endcase
        end
        state_next.serial = state_next.shifter[0];

        // Snapshots are copies only; the running counters are untouched
        if ((reg_wr || reg_rd) && (reg_addr == `SBT_ADDR_CAPTURE)) begin
            state_next.snap_scaler = scaler_count;
            state_next.snap_shift  = state_reg.shifter;
        end

        // Status read clears the request; a same-cycle set still wins
        if (reg_rd && (reg_addr == `SBT_ADDR_STATUS)) begin
            state_next.flag = 1'b0;
        end
        if (shift_tick && (state_reg.seq == SEQ_S1)) begin
            state_next.flag = 1'b1;
        end

        // Read data stand in the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                `SBT_ADDR_SCALE:   state_next.rd_data = state_reg.snap_scaler;
                `SBT_ADDR_SERIAL_OUT:  state_next.rd_data = state_reg.snap_shift;
                `SBT_ADDR_CAPTURE: state_next.rd_data = 8'h00;
                `SBT_ADDR_STATUS: begin
                    state_next.rd_data[`SBT_STAT_FLAG_BIT]                      = state_reg.flag;
                    state_next.rd_data[`SBT_STAT_FULL_BIT]                      = ~tx_ready;
                    state_next.rd_data[`SBT_STAT_SEQ_LSB+2:`SBT_STAT_SEQ_LSB] = state_reg.seq;
                end
            endcase
        end
    end

    // Register the whole state
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg             <= '0;
            state_reg.seq         <= SEQ_S0;
            state_reg.scale       <= `SBT_RST_SCALE;
            state_reg.last_byte   <= `SBT_RST_BYTE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata           = state_reg.rd_data;
    assign serial_out          = state_reg.serial;
    assign reload_request_flag = state_reg.flag;

endmodule
`default_nettype wire

// file: tb/sbt_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_top_chk (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic [1:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_ready,
    input wire logic       serial_out,
    input wire logic       reload_request_flag
);
    // One clock domain; everything is muted while reset holds
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // Read data is only driven in the answer cycle, so the bus stays quiet otherwise
    property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
    property p_cap_zero; reg_rd && reg_addr == 2'h2 |=> reg_rdata == 8'h00; endproperty
    a_cap_zero: assert property (p_cap_zero) else $error("capture read not zero");
    property p_stat_flag; reg_rd && reg_addr == 2'h3 |=> reg_rdata[0] == $past(reload_request_flag); endproperty
    a_stat_flag: assert property (p_stat_flag) else $error("status flag bit wrong");
    property p_stat_full; reg_rd && reg_addr == 2'h3 |=> reg_rdata[1] == !$past(tx_ready); endproperty
    a_stat_full: assert property (p_stat_full) else $error("status full bit wrong");
    // Sticky request: only a status read may take it down
    property p_flag_hold; reload_request_flag && !(reg_rd && reg_addr == 2'h3) |=> reload_request_flag; endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("reload request dropped");
    property p_flag_clr; $fell(reload_request_flag) |-> $past(reg_rd && reg_addr == 2'h3); endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("reload request cleared without read");
    property p_ready_fall; $fell(tx_ready) |-> $past(reg_wr && reg_addr == 2'h1); endproperty
    a_ready_fall: assert property (p_ready_fall) else $error("buffer filled without write");
    property p_rst_out; $fell(sys_rst) |-> tx_ready && !reload_request_flag && !serial_out; endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
endmodule
`default_nettype wire

// file: tb/sbt_host.sv
`timescale 1ns/1ps
`default_nettype none
module sbt_host (
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output logic [1:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    // Bus idle from time zero so no stray strobe reaches the block
    initial begin
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle write; the strobe drops after the edge that takes it
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read; data only stand in the cycle after the read edge
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: tb/sbt_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("ERROR %s expected %h seen %h", n, e, g); end end
module sbt_top_tb;
    logic       mclk;
    logic       sys_rst;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       tx_ready;
    logic       serial_out;
    logic       reload_request_flag;
    logic [7:0] v;
    int         err_count = 0;
    int         checked = 0;
    int         cyc = 0;

    // 10 MHz clock
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    sbt_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ready(tx_ready), .serial_out(serial_out),
        .reload_request_flag(reload_request_flag));
    sbt_host host_u (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Bounded wait for the reload request; n counts edges waited
    task automatic wait_flag(output int n);
        n = 0;
        while (reload_request_flag !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    // Zero scale divides by 256: first request lands one full span after reset
    task automatic t_rate;
        int n;
        wait_flag(n);
        `CHK("first tick span", 1'b1, (n >= 256 && n <= 258))
        host_u.wr(2'h0, 8'h04);
        $display("test rate done");
    endtask

    // Two bytes fill the buffer; a third is refused and a write to status is ignored
    task automatic t_fill;
        host_u.wr(2'h1, 8'hA5);
        host_u.wr(2'h1, 8'h3C);
        #1;
        `CHK("ready when full", 1'b0, tx_ready)
        host_u.wr(2'h1, 8'hFF);
        host_u.wr(2'h3, 8'hFF);
        host_u.rd(2'h3, v);
        `CHK("full bit", 1'b1, v[1])
        `CHK("flag bit", 1'b1, v[0])
        `CHK("sequencer field", sbt_pkg::SEQ_S2, v[4:2])
        `CHK("flag cleared", 1'b0, reload_request_flag)
        $display("test fill done");
    endtask

    // Bits 1..7 sampled mid-bit at a scale of 4, least significant first
    task automatic t_byte(input logic [7:0] b);
        int n;
        host_u.rd(2'h3, v);
        wait_flag(n);
        repeat (2) @(posedge mclk);
        for (int i = 1; i < 8; i++) begin
            #1;
            `CHK("serial bit", b[i], serial_out)
            if (i < 7) begin
                repeat (4) @(posedge mclk);
            end
        end
        $display("test byte %h done", b);
    endtask

    // Capture on the last bit of a byte; scaler snapshot must lie inside the running count
    task automatic t_snap;
        host_u.wr(2'h2, 8'h00);
        host_u.rd(2'h0, v);
        `CHK("scaler snapshot range", 1'b1, (v < 8'h04))
        // Capture lands on the last bit of A5, so only its top bit is left in the shifter
        host_u.rd(2'h1, v);
        `CHK("shifter snapshot", 8'h01, v)
        host_u.rd(2'h2, v);
        `CHK("capture read", 8'h00, v)
        `CHK("ready after load", 1'b1, tx_ready)
        $display("test snapshot done");
    endtask

    // Main sequence; the last byte repeats because nothing new was written
    initial begin
        sys_rst = 1'b1;
        repeat (11) @(posedge mclk);
        #1;
        `CHK("flag in reset", 1'b0, reload_request_flag)
        `CHK("line in reset", 1'b0, serial_out)
        @(posedge mclk);
        sys_rst <= 1'b0;
        t_rate();
        t_fill();
        t_byte(8'hA5);
        t_snap();
        t_byte(8'h3C);
        t_byte(8'h3C);
        give_verdict();
    end

    // Cycle ceiling; the run needs about 675 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end
endmodule

bind sbt_top sbt_top_chk chk_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_ready(tx_ready), .serial_out(serial_out),
    .reload_request_flag(reload_request_flag));
`default_nettype wire
